// File: dmasc_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
// requesters on the far side of the pins
module dmasc_periph_model (
  input wire logic aclk,
  input wire logic [1:0] req_want,
  input wire logic eop_want,
  output logic [1:0] channel_request_in,
  output logic end_of_process_n
);
  // pins move just after an edge, like a registered peripheral;
  // the first edge falls inside reset, so they are idle before use
  always @(posedge aclk) begin
    channel_request_in <= req_want;
    end_of_process_n <= ~eop_want; // active low pin
  end
endmodule // dmasc_periph_model
`default_nettype wire

// File: dmasc_pkg.sv
`default_nettype none
package dmasc_pkg;
  // register byte offsets on the bus
  localparam logic [15:0] OFF_STATUS = 16'hF008;
  localparam logic [15:0] OFF_CMD = 16'hF010;
  localparam logic [15:0] OFF_IRQ_STAT = 16'hF014;
  localparam logic [15:0] OFF_IRQ_EN = 16'hF018;
  localparam logic [15:0] OFF_IRQ_CLR = 16'hF01C;
  // status field positions
  localparam int TC0_BIT = 0;
  localparam int TC1_BIT = 1;
  localparam int REQ0_BIT = 4;
  localparam int REQ1_BIT = 5;
  // command field positions
  localparam int REQ_SEL_BIT = 0;
  localparam int EOP_SEL_BIT = 1;
  localparam int PL_LO = 2;
  // lowest priority encodings
  localparam logic [1:0] PL_CH0 = 2'h0;
  localparam logic [1:0] PL_CH1 = 2'h1;
  localparam logic [1:0] PL_HOLD = 2'h2;
  localparam logic [1:0] PL_RSVD = 2'h3;
  // values after reset
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [1:0] PL_RST = 2'h0;
  localparam logic SEL_RST = 1'b0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: dmasc_samp_if.sv
`timescale 1ns/100ps
`default_nettype none
// mode selects in, qualified levels out
interface dmasc_samp_if;
  logic req_sync_sel; // request_sync_sel bit
  logic eop_sync_sel; // end_of_process_sync_sel bit
  logic [1:0] req_level; // qualified requests
  logic eop_level; // end of process, active high
  modport ctrl (output req_sync_sel, output eop_sync_sel,
    input req_level, input eop_level);
  modport samp (input req_sync_sel, input eop_sync_sel,
    output req_level, output eop_level);
endinterface // dmasc_samp_if
`default_nettype wire

// File: dmasc_sampler.sv
`timescale 1ns/100ps
`default_nettype none
// samples the three pins; async mode adds a stability filter
module dmasc_sampler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [1:0] channel_request_in,
  input wire logic end_of_process_n,
  dmasc_samp_if.samp sp
);
  // pin order: {eop asserted, req1, req0}
  logic [2:0] s1; // first stage, read only by s2
  logic [2:0] s2; // second stage
  logic [2:0] s3; // previous settled sample
  logic [2:0] lvl; // qualified level
  logic [2:0] sel; // per-pin sync select
  assign sel = {sp.eop_sync_sel, {2{sp.req_sync_sel}}};
  // two-flop synchroniser, always present since pins are foreign
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
    end else if (ce) begin
      s1 <= {~end_of_process_n, channel_request_in};
      s2 <= s1;
      s3 <= s2;
    end
  end
  // sync mode takes each settled sample; async mode waits for two
  // equal samples, trading one cycle for immunity to glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl <= 3'h0;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (sel[i] || (s2[i] == s3[i])) begin
          lvl[i] <= s2[i];
        end
      end
    end
  end
  assign sp.req_level = lvl[1:0];
  assign sp.eop_level = lvl[2];
  // checked from the pin three edges back, so the first stage keeps
  // the second stage as its only reader
  chk_sync_req_path: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($past(ce && aresetn) && $past(ce && aresetn, 2) &&
     $past(ce && aresetn, 3) && $past(sp.req_sync_sel))
    |-> lvl[0] == $past(channel_request_in[0], 3))
    else $error("sync request path not two stages");
  chk_sync_eop_path: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($past(ce && aresetn) && $past(ce && aresetn, 2) &&
     $past(ce && aresetn, 3) && $past(sp.eop_sync_sel))
    |-> lvl[2] == !$past(end_of_process_n, 3))
    else $error("sync eop path not two stages");
  chk_async_filter_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && !sel[2] && s2[2] != s3[2]) |=> $stable(lvl[2]))
    else $error("async eop took an unsettled sample");
endmodule // dmasc_sampler
`default_nettype wire

// File: dmasc_top.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module dmasc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [15:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [15:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins from requesters
  input wire logic [1:0] channel_request_in,
  input wire logic end_of_process_n,
  // transfer engine, same clock
  input wire logic [1:0] byte_count_expired,
  input wire logic xfer_active,
  input wire logic xfer_channel,
  input wire logic rotate_enable,
  input wire logic grant_valid,
  input wire logic [1:0] grant_who,
  // towards engine and arbiter
  output logic [1:0] request_level,
  output logic eop_level,
  output logic [1:0] lowest_priority_select,
  output logic irq
);

  // address match shared by read and write decode
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] off);
    return a[15:2] == off[15:2];
  endfunction

  dmasc_samp_if sp ();

  // captured write address and data
  logic [15:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0; // byte lane 0 enabled
  logic wr_go; // both halves held, answer not yet out
  logic ar_go; // read address taken this cycle
  logic rd_status; // status read side effect
  logic wr_cmd; // command register written
  logic wr_irq_en; // enable register written
  logic wr_irq_clr; // clear register written
  logic wr_ok; // address mapped for writing
  logic rd_ok; // address mapped for reading

  // software visible state and completion detect
  logic [1:0] tc; // sticky done flags
  logic req_sync_sel; // request sampling mode
  logic eop_sync_sel; // eop sampling mode
  logic [1:0] irq_stat; // sticky interrupt causes
  logic [1:0] irq_en; // interrupt enables
  logic eop_prev; // eop level one cycle back
  logic eop_rise; // new end of process seen
  logic [1:0] done_evt; // per-channel completion

  // decode
  assign wr_go = !awready && !wready && !bvalid;
  assign ar_go = arvalid && arready;
  assign wr_cmd = wr_go && w_lane0 && hit(aw_addr, dmasc_pkg::OFF_CMD);
  assign wr_irq_en = wr_go && w_lane0 &&
    hit(aw_addr, dmasc_pkg::OFF_IRQ_EN);
  assign wr_irq_clr = wr_go && w_lane0 &&
    hit(aw_addr, dmasc_pkg::OFF_IRQ_CLR);
  assign wr_ok = hit(aw_addr, dmasc_pkg::OFF_CMD) ||
    hit(aw_addr, dmasc_pkg::OFF_IRQ_EN) ||
    hit(aw_addr, dmasc_pkg::OFF_IRQ_CLR);
  assign rd_ok = hit(araddr, dmasc_pkg::OFF_STATUS) ||
    hit(araddr, dmasc_pkg::OFF_IRQ_STAT) ||
    hit(araddr, dmasc_pkg::OFF_IRQ_EN);
  assign rd_status = ar_go && hit(araddr, dmasc_pkg::OFF_STATUS);

  // completion: byte count ran out, or eop arrived on the
  // active channel; only the eop edge counts so a held pin
  // does not refill the flag after every read
  assign eop_rise = sp.eop_level && !eop_prev;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      done_evt[i] = byte_count_expired[i] ||
        (eop_rise && xfer_active && (xfer_channel == i[0]));
    end
  end

  // mode bits to the sampler
  assign sp.req_sync_sel = req_sync_sel;
  assign sp.eop_sync_sel = eop_sync_sel;

  dmasc_sampler u_samp (
    .aclk (aclk),
    .aresetn (aresetn),
    .ce (ce),
    .channel_request_in (channel_request_in),
    .end_of_process_n (end_of_process_n),
    .sp (sp)
  );

  // pass qualified levels; they are flops in the sampler
  assign request_level = sp.req_level;
  assign eop_level = sp.eop_level;

  // write address channel: hold one address until answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr <= 16'h0000;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  // write data channel: held separately, either order works
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  // write response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= dmasc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        // status is read only: a write there is an error
        bresp <= wr_ok ? dmasc_pkg::RESP_OKAY
                       : dmasc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel: one read at a time, data a cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= dmasc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= rd_ok ? dmasc_pkg::RESP_OKAY
                       : dmasc_pkg::RESP_SLVERR;
        rdata <= 32'h0000_0000;
        if (hit(araddr, dmasc_pkg::OFF_STATUS)) begin
          // reserved bits read zero
          rdata[dmasc_pkg::REQ1_BIT] <= sp.req_level[1];
          rdata[dmasc_pkg::REQ0_BIT] <= sp.req_level[0];
          rdata[dmasc_pkg::TC1_BIT] <= tc[1];
          rdata[dmasc_pkg::TC0_BIT] <= tc[0];
        end else if (hit(araddr, dmasc_pkg::OFF_IRQ_STAT)) begin
          rdata[1:0] <= irq_stat;
        end else if (hit(araddr, dmasc_pkg::OFF_IRQ_EN)) begin
          rdata[1:0] <= irq_en;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // done flags: a new completion beats the read clear,
  // so an event in the reading cycle is not lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tc <= dmasc_pkg::STATUS_RST[1:0];
      eop_prev <= 1'b0;
    end else if (ce) begin
      eop_prev <= sp.eop_level;
      for (int i = 0; i < 2; i++) begin
        if (done_evt[i]) begin
          tc[i] <= 1'b1;
        end else if (rd_status) begin
          tc[i] <= 1'b0;
        end
      end
    end
  end

  // command register: only bits 3-0 exist, upper bits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_sync_sel <= dmasc_pkg::SEL_RST;
      eop_sync_sel <= dmasc_pkg::SEL_RST;
    end else if (ce && wr_cmd) begin
      req_sync_sel <= w_data[dmasc_pkg::REQ_SEL_BIT];
      eop_sync_sel <= w_data[dmasc_pkg::EOP_SEL_BIT];
    end
  end

  // lowest priority: software write wins over a rotation step in
  // the same cycle; the reserved code leaves the choice as it was
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lowest_priority_select <= dmasc_pkg::PL_RST;
    end else if (ce) begin
      if (wr_cmd) begin
        if (w_data[dmasc_pkg::PL_LO +: 2] != dmasc_pkg::PL_RSVD) begin
          lowest_priority_select <= w_data[dmasc_pkg::PL_LO +: 2];
        end
      end else if (rotate_enable && grant_valid &&
                   grant_who != dmasc_pkg::PL_RSVD) begin
        lowest_priority_select <= grant_who;
      end
    end
  end

  // interrupt enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= dmasc_pkg::IRQ_RST;
    end else if (ce && wr_irq_en) begin
      irq_en <= w_data[1:0];
    end
  end

  // interrupt causes: completions, cleared by writing ones,
  // a completion in the clearing cycle keeps its bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= dmasc_pkg::IRQ_RST;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (done_evt[i]) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_irq_clr && w_data[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt line, registered so it lags the cause by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat & irq_en);
    end
  end

  chk_req_bits_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && rd_status) |=>
    rdata[5:4] == $past(sp.req_level))
    else $error("request bits do not follow live requests");
  chk_tc1_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && done_evt[1]) |=> tc[1])
    else $error("channel 1 done flag not set");
  chk_tc0_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && done_evt[0]) |=> tc[0])
    else $error("channel 0 done flag not set");
  chk_read_clears_done: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && rd_status && !done_evt[0] && !done_evt[1]) |=> tc == 2'h0)
    else $error("status read did not clear done flags");
  chk_reserved_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && rd_status) |=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0)
    else $error("reserved status bits not zero");
  chk_low_prio_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_cmd && w_data[3:2] != 2'h3) |=>
    lowest_priority_select == $past(w_data[3:2]))
    else $error("lowest priority not taken from write");
  chk_mode_bits_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_cmd) |=> {eop_sync_sel, req_sync_sel} ==
    $past(w_data[1:0]))
    else $error("sampling mode bits not stored");
  chk_rotate_grant: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && !wr_cmd && rotate_enable && grant_valid &&
     grant_who != 2'h3) |=> lowest_priority_select == $past(grant_who))
    else $error("rotation did not move grantee to lowest");
  chk_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_go) |=> bvalid)
    else $error("write not answered next cycle");
  chk_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && ar_go) |=> rvalid)
    else $error("read not answered next cycle");
  // the line is a flop, so it trails the enabled causes by one edge
  chk_irq_level: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce |=> irq == $past(|(irq_stat & irq_en)))
    else $error("interrupt line does not follow enabled causes");

endmodule // dmasc_top
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, eop_level;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, req_want, byte_count_expired, grant_who;
  logic [1:0] request_level, lowest_priority_select, channel_request_in;
  logic eop_want, end_of_process_n, xfer_active, xfer_channel;
  logic rotate_enable, grant_valid;
  int n_mismatch, n_compared;
  logic [31:0] d;
  logic [1:0] r;
  dmasc_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .channel_request_in(channel_request_in),
    .end_of_process_n(end_of_process_n),
    .byte_count_expired(byte_count_expired), .xfer_active(xfer_active),
    .xfer_channel(xfer_channel), .rotate_enable(rotate_enable),
    .grant_valid(grant_valid), .grant_who(grant_who),
    .request_level(request_level), .eop_level(eop_level),
    .lowest_priority_select(lowest_priority_select), .irq(irq));
  dmasc_periph_model u_periph (.aclk(aclk), .req_want(req_want),
    .eop_want(eop_want), .channel_request_in(channel_request_in),
    .end_of_process_n(end_of_process_n));
  // 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one write; an edge first so strobes are never set twice in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, v}; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp; bready <= 1'b0; done = 1'b1;
      end
    end
  endtask
  // one read, result in d and r
  task automatic rd(input logic [15:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata; r = rresp; rready <= 1'b0; done = 1'b1;
      end
    end
  endtask
  // one-cycle done pulse from the engine
  task automatic pulse_done(input logic [1:0] m);
    @(posedge aclk) byte_count_expired <= m;
    @(posedge aclk) byte_count_expired <= 2'h0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_reset();
    rd(dmasc_pkg::OFF_STATUS);
    chk("status after reset", d, 32'h0);
    chk("read resp", {30'h0, r}, {30'h0, dmasc_pkg::RESP_OKAY});
    chk("lowest prio", {30'h0, lowest_priority_select}, 32'h0);
  endtask
  // request flags follow the pins both ways
  task automatic t_request();
    logic [1:0] pat [3] = '{2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 3; i++) begin
      req_want <= pat[i];
      repeat (8) @(posedge aclk);
      rd(dmasc_pkg::OFF_STATUS);
      chk("req flags", d, {26'h0, pat[i], 4'h0});
    end
  endtask
  // done flags set, read clears them but not the request flags
  task automatic t_done();
    req_want <= 2'h3;
    pulse_done(2'h3);
    rd(dmasc_pkg::OFF_STATUS);
    chk("done set", d, 32'h33);
    rd(dmasc_pkg::OFF_STATUS);
    chk("done cleared", d, 32'h30);
    req_want <= 2'h0;
  endtask
  // interrupt raise, clear and mask
  task automatic t_irq();
    // earlier done pulses left both causes set: start clean
    wr(dmasc_pkg::OFF_IRQ_CLR, 8'h03);
    wr(dmasc_pkg::OFF_IRQ_EN, 8'h01);
    pulse_done(2'h1);
    chk("irq on", {31'h0, irq}, 32'h1);
    rd(dmasc_pkg::OFF_IRQ_STAT);
    chk("irq stat", d, 32'h1);
    wr(dmasc_pkg::OFF_IRQ_CLR, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    pulse_done(2'h2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(dmasc_pkg::OFF_IRQ_CLR, 8'h03);
    rd(dmasc_pkg::OFF_STATUS);
  endtask
  // every priority code, the reserved one keeps the last value
  task automatic t_cmd();
    logic [1:0] want;
    want = 2'h0;
    for (int i = 0; i < 4; i++) begin
      wr(dmasc_pkg::OFF_CMD, {4'h0, 2'(i), 2'h0});
      if (2'(i) != dmasc_pkg::PL_RSVD) want = 2'(i);
      @(posedge aclk);
      chk("prio code", {30'h0, lowest_priority_select}, {30'h0, want});
    end
    rd(dmasc_pkg::OFF_CMD);
    chk("cmd read", {30'h0, r}, {30'h0, dmasc_pkg::RESP_SLVERR});
    rd(16'hF000);
    chk("unmapped read", {d[29:0], r}, {30'h0, dmasc_pkg::RESP_SLVERR});
    wr(dmasc_pkg::OFF_STATUS, 8'hFF);
    chk("ro write", {30'h0, r}, {30'h0, dmasc_pkg::RESP_SLVERR});
  endtask
  // async sampling takes one edge more than sync; eop ends channel 1
  task automatic t_sample();
    int nr [2], ne [2];
    for (int m = 0; m < 2; m++) begin
      wr(dmasc_pkg::OFF_CMD, {6'h0, 1'(m), 1'(m)});
      xfer_active <= 1'b1; xfer_channel <= 1'b1;
      @(posedge aclk);
      req_want <= 2'h1; eop_want <= 1'b1;
      nr[m] = 0; ne[m] = 0;
      for (int k = 1; k < 12; k++) begin
        @(posedge aclk);
        if (nr[m] == 0 && request_level === 2'h1) nr[m] = k;
        if (ne[m] == 0 && eop_level === 1'b1) ne[m] = k;
      end
      rd(dmasc_pkg::OFF_STATUS);
      chk("eop done", d, 32'h12);
      req_want <= 2'h0; eop_want <= 1'b0; xfer_active <= 1'b0;
      repeat (8) @(posedge aclk);
    end
    chk("sync req", 32'(nr[1] + 1), 32'(nr[0]));
    chk("sync eop", 32'(ne[1] + 1), 32'(ne[0]));
    chk("req seen", 32'(nr[1] > 0), 32'h1);
  endtask
  // rotation loads the last granted requester
  task automatic t_rotate();
    for (int w = 2; w >= 0; w--) begin
      @(posedge aclk);
      rotate_enable <= 1'b1; grant_valid <= 1'b1; grant_who <= 2'(w);
      @(posedge aclk) grant_valid <= 1'b0;
      @(posedge aclk);
      chk("rotate", {30'h0, lowest_priority_select}, 32'(w));
    end
  endtask
  // counts, verdict, end of run
  task automatic test_done();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    test_done();
  end
  initial begin
    n_mismatch = 0; n_compared = 0;
    aresetn = 1'b0; awaddr = 16'h0; araddr = 16'h0; wdata = 32'h0;
    wstrb = 4'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; req_want = 2'h0; eop_want = 1'b0;
    byte_count_expired = 2'h0; xfer_active = 1'b0; xfer_channel = 1'b0;
    rotate_enable = 1'b0; grant_valid = 1'b0; grant_who = 2'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_request();
    t_done();
    t_irq();
    t_cmd();
    t_sample();
    t_rotate();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
